// *** sarq_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host serial port: frames select, shift clock 125 ns, reads data before each fall
module sarq_host_model (
  input  wire logic core_clk,
  input  wire logic serial_result_out,
  input  wire logic serial_result_oe,
  output var logic  device_select_n,
  output var logic  serial_shift_clock
);
  logic data_pin;        // resolved data wire
  logic last_bit = 1'b0; // last wire level
  // no pull on the wire: released level toggles so nothing passes by luck
  assign data_pin = serial_result_oe ? serial_result_out : ~last_bit;
  always @(posedge core_clk) last_bit <= data_pin;
  initial begin
    device_select_n = 1'b1;
    serial_shift_clock = 1'b0; // idle low between frames
  end
  // shift pulses while deselected, all must be ignored; after a short frame
  // a design that counted them would start a stray conversion
  task automatic stray_clock(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk) serial_shift_clock = 1'b1;
      repeat (12) @(negedge core_clk);
      serial_shift_clock = 1'b0;
      repeat (12) @(negedge core_clk);
    end
  endtask
  // one transfer of n clocks; keep leaves select low for continuous mode
  // pin changes fall on core falling edges, 25 core cycles per shift clock
  task automatic transfer(input int n, input bit keep, output logic [15:0] word);
    word = 16'h0000;
    @(negedge core_clk) device_select_n = 1'b0;
    repeat (24) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin // n never above 16, no gap after tenth
      @(negedge core_clk) serial_shift_clock = 1'b1;
      repeat (12) @(negedge core_clk);
      word[15-i] = data_pin;
      serial_shift_clock = 1'b0;
      repeat (12) @(negedge core_clk);
    end
    if (!keep) begin
      @(negedge core_clk) device_select_n = 1'b1;
      stray_clock(6);
    end
    repeat (200) @(negedge core_clk); // beyond scaled conversion time
  endtask
endmodule
`default_nettype wire

// *** sarq_pkg.sv ***
`default_nettype none
package sarq_pkg;
  // result word
  localparam int RESULT_BITS       = 10;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // shift clock falling edge numbers within one transfer
  localparam logic [4:0] SAMPLE_START_EDGE = 5'h03;
  localparam logic [4:0] HANDOFF_EDGE      = 5'h0A;
  localparam logic [4:0] MAX_EDGES         = 5'h10;
  // timing, core clock at 200 MHz
  localparam int CLK_PERIOD_NS     = 5;
  localparam int CONV_TIME_NS      = 21000;
  localparam int SEL_HOLD_NS       = 1425;
  // longest time rounds down, one step per result bit
  localparam int STEP_CYCLES       = CONV_TIME_NS / CLK_PERIOD_NS / RESULT_BITS;
  // least time rounds up
  localparam int SEL_HOLD_CYCLES   = (SEL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // synchroniser depth
  localparam int SYNC_STAGES       = 2;
  // conversion controller states
  typedef enum logic [1:0] {
    SARQ_IDLE    = 2'b00,
    SARQ_CONVERT = 2'b01
  } sarq_state_t;
endpackage
`default_nettype wire

// *** sarq_sequencer.sv ***
// How it works
// RQ1 - select fall resets counters, enables output
// RQ2 - select rise stops shift clock response
// RQ3 - output floats with select high, driven low
// RQ4 - valid select presents previous result MSB
// RQ5 - each falling edge shifts next lower bit
// RQ6 - tenth edge onward output stays low
// RQ7 - sample from third to tenth edge
// RQ8 - tenth edge hands conversion to controller
// RQ9 - successive approximation gives held 10-bit result
// RQ10 - host waits conversion time before next transfer
// RQ11 - host sends at most sixteen shift clocks
// RQ12 - host raises eleventh clock in time
// RQ13 - select level counts only when held
// RQ14 - pins synchronised before edges are used
`timescale 1ns/1ps
`default_nettype none
module sarq_sequencer
  import sarq_pkg::*;
#(
  parameter int STEP_CNT = sarq_pkg::STEP_CYCLES,     // core cycles per approximation step
  parameter int SEL_HOLD = sarq_pkg::SEL_HOLD_CYCLES  // cycles a select level must last
) (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   device_select_n,
  input  wire logic                   serial_shift_clock,
  input  wire logic                   comparator_above,
  output logic                        serial_result_out,
  output logic                        serial_result_oe,
  output logic                        sample_enable,
  output logic [sarq_pkg::RESULT_BITS-1:0] dac_trial,
  output logic                        conv_busy
);
  import sarq_pkg::*;

  logic                   sel_n_s;       // synchronised select, active low
  logic                   sclk_s;        // synchronised shift clock
  logic                   cmp_s;         // synchronised comparator decision
  logic                   sel_n_d;       // previous select level
  logic                   sclk_d;        // previous shift clock level
  logic                   sel_fall;      // select went active
  logic                   sclk_fall;     // accepted shift clock falling edge
  logic [8:0]             hold_cnt;      // cycles since last select change
  logic [4:0]             edge_cnt;      // falling edges in this transfer
  logic [RESULT_BITS-1:0] shreg;         // outgoing result bits
  logic [RESULT_BITS-1:0] result;        // last finished conversion
  logic                   conv_done;     // one-cycle pulse, result updated
  logic                   restart_pend;  // continuous select, wait for 16th edge
  logic                   conv_start;    // tenth edge seen
  sarq_state_t            state;         // conversion controller state
  logic [8:0]             step_cnt;      // divider for approximation steps
  logic                   step_en;       // one-cycle step enable
  logic [3:0]             bit_idx;       // bit under trial
  logic                   restart;       // begin next transfer without select toggle

  // pins into the core clock domain
  sarq_sync #(.RESET_VALUE(1'b1)) u_sync_sel (  // [RQ14]
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (device_select_n),
    .sync_out (sel_n_s)
  );
  sarq_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (  // [RQ14]
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (serial_shift_clock),
    .sync_out (sclk_s)
  );
  sarq_sync #(.RESET_VALUE(1'b0)) u_sync_cmp (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (comparator_above),
    .sync_out (cmp_s)
  );

  // edge history
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_d <= 1'b1;
      sclk_d  <= 1'b0;
    end else begin
      sel_n_d <= sel_n_s;
      sclk_d  <= sclk_s;
    end
  end

  // a fall only counts after the high level was held long enough
  assign sel_fall  = sel_n_d && !sel_n_s && (hold_cnt >= 9'(SEL_HOLD));  // [RQ13]
  // shift clock ignored while select is inactive
  assign sclk_fall = sclk_d && !sclk_s && !sel_n_s && !sel_n_d;  // [RQ2]

  // level age counter, saturates at the hold time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= 9'h000;
    end else if (sel_n_d != sel_n_s) begin
      hold_cnt <= 9'h000;
    end else if (hold_cnt < 9'(SEL_HOLD)) begin
      hold_cnt <= hold_cnt + 9'h001;
    end
  end

  // continuous select: next transfer starts once the result is in
  assign restart = !sel_n_s && ((conv_done && edge_cnt == HANDOFF_EDGE)
                   || (restart_pend && edge_cnt == MAX_EDGES));

  // transfer bit counter and output shifter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      edge_cnt <= 5'h00;
      shreg    <= RESULT_RESET;
    end else if (sel_fall || restart) begin
      edge_cnt <= 5'h00;  // [RQ1]
      shreg    <= result;  // [RQ4] [RQ9]
    end else if (sclk_fall) begin
      if (edge_cnt < MAX_EDGES) begin
        edge_cnt <= edge_cnt + 5'h01;
      end
      // zero fill: ninth edge shows the lsb, tenth and later show low
      shreg <= {shreg[RESULT_BITS-2:0], 1'b0};  // [RQ5] [RQ6]
    end
  end

  // extra clocks beyond sixteen only repeat zeros
  assign conv_start = sclk_fall && (edge_cnt == HANDOFF_EDGE - 5'h01);  // [RQ8]

  // pending restart for sixteen clock continuous transfers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      restart_pend <= 1'b0;
    end else if (sel_fall || restart || sel_n_s) begin
      restart_pend <= 1'b0;
    end else if (conv_done && edge_cnt > HANDOFF_EDGE) begin
      restart_pend <= 1'b1;
    end
  end

  // sampling window, third edge until tenth edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sample_enable <= 1'b0;
    end else if (sel_fall || restart || sel_n_s) begin
      sample_enable <= 1'b0;
    end else if (sclk_fall && edge_cnt == SAMPLE_START_EDGE - 5'h01) begin
      sample_enable <= 1'b1;  // [RQ7]
    end else if (conv_start) begin
      sample_enable <= 1'b0;  // [RQ7]
    end
  end

  // output enable follows the synchronised select
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_result_oe <= 1'b0;
    end else begin
      serial_result_oe <= !sel_n_s;  // [RQ3] [RQ1]
    end
  end

  // driven value stays low while floating
  assign serial_result_out = shreg[RESULT_BITS-1] & serial_result_oe;  // [RQ3]

  // step divider, runs only during conversion
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt <= 9'h000;
      step_en  <= 1'b0;
    end else if (state != SARQ_CONVERT || step_cnt == 9'(STEP_CNT - 1)) begin
      step_cnt <= 9'h000;
      step_en  <= (state == SARQ_CONVERT);
    end else begin
      step_cnt <= step_cnt + 9'h001;
      step_en  <= 1'b0;
    end
  end

  // conversion controller, independent of the shift clock once started;
  // select changes do not abort it, the previous result would be lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= SARQ_IDLE;
      bit_idx   <= 4'h0;
      dac_trial <= RESULT_RESET;
      result    <= RESULT_RESET;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state)
        SARQ_IDLE: begin
          if (conv_start) begin
            state     <= SARQ_CONVERT;  // [RQ8]
            bit_idx   <= 4'(RESULT_BITS - 1);
            dac_trial <= {1'b1, {(RESULT_BITS-1){1'b0}}};
          end
        end
        SARQ_CONVERT: begin
          if (step_en) begin
            // keep the trial bit only when the input is at or above it
            if (bit_idx == 4'h0) begin
              state     <= SARQ_IDLE;
              result    <= {dac_trial[RESULT_BITS-1:1], cmp_s};  // [RQ9]
              dac_trial <= {dac_trial[RESULT_BITS-1:1], cmp_s};
              conv_done <= 1'b1;
            end else begin
              dac_trial[bit_idx]        <= cmp_s;  // [RQ9]
              dac_trial[bit_idx - 4'h1] <= 1'b1;
              bit_idx                   <= bit_idx - 4'h1;
            end
          end
        end
        default: begin
          state <= SARQ_IDLE;
        end
      endcase
    end
  end

  assign conv_busy = (state == SARQ_CONVERT);
endmodule
`default_nettype wire

// *** sarq_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sarq_sequencer_assertions
  import sarq_pkg::*;
#(
  parameter int STEP_CNT = sarq_pkg::STEP_CYCLES,    // core cycles per approximation step
  parameter int SEL_HOLD = sarq_pkg::SEL_HOLD_CYCLES // cycles a select level must last
) (
  input wire logic                           core_clk,
  input wire logic                           resetn,
  input wire logic                           device_select_n,
  input wire logic                           serial_shift_clock,
  input wire logic                           comparator_above,
  input wire logic                           serial_result_out,
  input wire logic                           serial_result_oe,
  input wire logic                           sample_enable,
  input wire logic [sarq_pkg::RESULT_BITS-1:0] dac_trial,
  input wire logic                           conv_busy
);
  int busy_len; // cycles the conversion has run so far
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // conversion length counter, too long for a repetition
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) busy_len <= 0;
    else busy_len <= conv_busy ? busy_len + 1 : 0;
  end
  // select held one level past the synchroniser delay
  sequence sel_hi_s; device_select_n [*4]; endsequence
  sequence sel_lo_s; !device_select_n [*4]; endsequence
  oe_off_a: assert property (sel_hi_s |-> !serial_result_oe)
    else $error("data enabled while deselected");
  oe_on_a: assert property (sel_lo_s |-> serial_result_oe)
    else $error("data floating while selected");
  data_quiet_a: assert property (!serial_result_oe |-> !serial_result_out)
    else $error("data bit set while released");
  oe_rise_a: assert property ($rose(serial_result_oe) |-> !$past(device_select_n, 2))
    else $error("enable without select");
  busy_start_a: assert property ($rose(conv_busy) |-> $fell(sample_enable) && dac_trial == 10'h200)
    else $error("conversion start wrong");
  busy_len_a: assert property ($fell(conv_busy) |-> busy_len >= 10 * STEP_CNT && busy_len <= 10 * STEP_CNT + 3)
    else $error("conversion length wrong");
  no_overlap_a: assert property (sample_enable |-> !conv_busy)
    else $error("sampling during conversion");
  sample_sel_a: assert property ($rose(sample_enable) |-> !$past(device_select_n, 3))
    else $error("sampling without select");
  tail_zero_a: assert property ($fell(sample_enable) && serial_result_oe |-> !serial_result_out)
    else $error("data not low at tenth edge");
endmodule
bind sarq_sequencer sarq_sequencer_assertions #(.STEP_CNT(STEP_CNT), .SEL_HOLD(SEL_HOLD)) chk_i (
  .core_clk, .resetn, .device_select_n, .serial_shift_clock, .comparator_above,
  .serial_result_out, .serial_result_oe, .sample_enable, .dac_trial, .conv_busy);
`default_nettype wire

// *** sarq_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sarq_sequencer_tb_top;
  import sarq_pkg::*;
  logic        core_clk, resetn, device_select_n, serial_shift_clock;
  logic        comparator_above, serial_result_out, serial_result_oe;
  logic        sample_enable, conv_busy;
  logic [9:0]  dac_trial;
  logic [9:0]  analog_level = 10'h000; // modelled input voltage
  logic [9:0]  prev;                   // result the next transfer shows
  logic [15:0] word;                   // bits caught by the host
  int          seed = 32'hE6982993;
  int          fails = 0, check_count = 0, cyc = 0, n;
  sarq_sequencer #(.STEP_CNT(8), .SEL_HOLD(3)) uut (.core_clk, .resetn, .device_select_n,
    .serial_shift_clock, .comparator_above, .serial_result_out, .serial_result_oe,
    .sample_enable, .dac_trial, .conv_busy);
  sarq_host_model host (.core_clk, .serial_result_out, .serial_result_oe,
    .device_select_n, .serial_shift_clock);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // comparator: input at or above the trial code keeps the bit
  always @(negedge core_clk) comparator_above <= (analog_level >= dac_trial);
  // bits past the tenth read as zero
  function automatic logic [15:0] expect_word(input logic [9:0] r, input int k);
    return {r, 6'h00} & ~(16'hFFFF >> k);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, runs need about 6000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) resetn = 1'b1;
    #200;
    prev = 10'h000; // reset result
    // corners first: ten, sixteen, aborted frame, then select held low over
    // a ten and a sixteen clock transfer; then random lengths
    for (int t = 0; t < 9; t++) begin
      n = (t == 0 || t == 3 || t == 5) ? 10 : (t == 1 || t == 4) ? 16 :
          (t == 2) ? 5 : 10 + int'($unsigned($random(seed)) % 7);
      analog_level = 10'($random(seed));
      host.transfer(n, (t == 3 || t == 4), word);
      chk(word, expect_word(prev, n));
      if (n >= 10) prev = analog_level;
      $display("test %0d with %0d clocks done", t, n);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** sarq_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one pin level
module sarq_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;  // first stage, read only by the second

  // capture then settle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta     <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire
